// >>> rtl/spwss_top.sv
// Wake status capture, wake enables and SMI source gating with Avalon-MM slave
`timescale 1ns/1ps
module spwss_top
   import spwss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [AVS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [AVS_BE_W-1:0] avs_byteenable,
   input wire logic [AVS_DATA_W-1:0] avs_writedata,
   output logic [AVS_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire spwss_wake_pins_type wakePins,
   input wire logic rtcAlarm,
   input wire logic clockAlarmSecond,
   input wire spwss_periph_irq_type periphIrq,
   output logic powerOnRequest,
   output logic groupSmi,
   output logic systemMgmtIrq_n,
   output logic systemMgmtIrqOe_n,
   output logic irq
);

   spwss_top_state_type st_r;
   spwss_top_state_type st_nxt;

   logic [7:0] syncPins;
   logic [LATCH_N-1:0] latchIn;
   logic [LATCH_N-1:0] latchClr;
   logic [LATCH_N-1:0] latchFlag;
   logic [LATCH_N-1:0] latchSet;
   logic [7:0] statusA;
   logic [7:0] statusB;
   logic [7:0] regIdx;
   logic readTake;
   logic writeTake;
   logic readClrA;
   logic readClrB;
   logic groupSmiNow;
   logic [7:0] irqSet;
   logic [7:0] irqW1c;
   logic [7:0] wData;

   ////////////////////////////////////////////////////////////////////////
   // Pin inputs cross from outside the clock domain
   spwss_sync #(
      .W(8),
      .RESET_VAL(RST_PINS)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .asyncIn(wakePins),
      .syncOut(syncPins)
   );

   // Alarms are internal and same-clock, so they skip the synchroniser
   always_comb begin
      latchIn = '0;
      latchIn[L_RING_A] = syncPins[0];
      latchIn[L_RING_B] = syncPins[1];
      latchIn[L_KBD_CLK] = syncPins[2];
      latchIn[L_MOUSE_CLK] = syncPins[3];
      latchIn[L_IR_RX_B] = syncPins[4];
      latchIn[L_SER_RX_A] = syncPins[5];
      latchIn[L_SER_RX_B] = syncPins[6];
      latchIn[L_BUTTON] = syncPins[7];
      latchIn[L_ALARM] = rtcAlarm;
      latchIn[L_ALARM_B] = clockAlarmSecond;
   end

   ////////////////////////////////////////////////////////////////////////
   // Event latches
   for (genvar i = 0; i < LATCH_N; i++) begin : g_latch
      spwss_event_latch #(
         .SET_ON_FALL(LATCH_EDGE_MASK[i])
      ) u_latch (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .sample(latchIn[i]),
         .clear(latchClr[i]),
         .flag(latchFlag[i]),
         .setPulse(latchSet[i])
      );
   end

   always_comb begin
      statusA = {latchFlag[L_ALARM],
                 latchFlag[L_IR_RX_B],
                 periphIrq.groupIrqB,
                 periphIrq.groupIrqA,
                 latchFlag[L_MOUSE_CLK],
                 latchFlag[L_KBD_CLK],
                 latchFlag[L_RING_B],
                 latchFlag[L_RING_A]};
      statusB = {3'h0,
                 latchFlag[L_ALARM_B],
                 1'h0,
                 latchFlag[L_BUTTON],
                 latchFlag[L_SER_RX_B],
                 latchFlag[L_SER_RX_A]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus decode: read data captured on the first edge, answer on the second
   always_comb begin
      regIdx = avs_address[AVS_ADDR_W-1:2];
      readTake = avs_read & ~st_r.ack;
      writeTake = avs_write & st_r.ack & avs_byteenable[0];
      wData = avs_writedata[7:0];
      readClrA = readTake & (regIdx == IDX_STATUS_A);
      readClrB = readTake & (regIdx == IDX_STATUS_B);
      latchClr = ({LATCH_N{readClrA}} & CLR_BY_A_MASK) | ({LATCH_N{readClrB}} & CLR_BY_B_MASK);
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
   assign avs_readdata = {24'h000000, st_r.readData};

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      irqW1c = 8'h00;
      st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
      if (readTake) begin
         unique case (regIdx)
            IDX_WAKE_EN_A: st_nxt.readData = st_r.wakeEnA;
            IDX_WAKE_EN_B: st_nxt.readData = st_r.wakeEnB;
            IDX_STATUS_A: st_nxt.readData = statusA;
            IDX_STATUS_B: st_nxt.readData = statusB;
            IDX_SMI_EN_A: st_nxt.readData = st_r.smiEn;
            IDX_SMI_PIN_CTL: st_nxt.readData = st_r.pinCtl;
            IDX_IRQ_STATUS: st_nxt.readData = st_r.irqStatus;
            IDX_IRQ_MASK: st_nxt.readData = st_r.irqMask;
            default: st_nxt.readData = 8'h00;
         endcase
      end
      // Wake status registers A and B are read-only; writes to them drop
      if (writeTake) begin
         unique case (regIdx)
            IDX_WAKE_EN_A: st_nxt.wakeEnA = wData;
            IDX_WAKE_EN_B: st_nxt.wakeEnB = wData;
            IDX_SMI_EN_A: st_nxt.smiEn = wData;
            IDX_SMI_PIN_CTL: st_nxt.pinCtl = wData & SMI_PIN_CTL_MASK;
            IDX_IRQ_STATUS: irqW1c = wData;
            IDX_IRQ_MASK: st_nxt.irqMask = wData & IRQ_IMPL_MASK;
            default: ;
         endcase
      end

      groupSmiNow = |(st_r.smiEn & periphIrq);
      st_nxt.groupSmi = groupSmiNow;
      st_nxt.smiPinOut = ~groupSmiNow;
      st_nxt.smiPinOe_n = ~st_r.pinCtl[SMI_PIN_EN_BIT];

      // Button status is left out of the power request
      st_nxt.powerOn = |(statusA & st_r.wakeEnA) |
                       |(statusB & st_r.wakeEnB & WAKE_EN_B_POWER_MASK);

      irqSet = 8'h00;
      irqSet[IRQ_WAKE_A] = |latchSet[L_ALARM:L_RING_A];
      irqSet[IRQ_WAKE_B] = latchSet[L_SER_RX_A] | latchSet[L_SER_RX_B] | latchSet[L_ALARM_B];
      irqSet[IRQ_BUTTON] = latchSet[L_BUTTON];
      irqSet[IRQ_SMI] = groupSmiNow & ~st_r.groupSmi;
      st_nxt.irqStatus = irqSet | (st_r.irqStatus & ~irqW1c);
      st_nxt.irq = |(st_nxt.irqStatus & st_r.irqMask);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r.wakeEnA <= RST_WAKE_EN_A;
         st_r.wakeEnB <= RST_WAKE_EN_B;
         st_r.smiEn <= RST_SMI_EN;
         st_r.pinCtl <= RST_PIN_CTL;
         st_r.irqStatus <= RST_IRQ;
         st_r.irqMask <= RST_IRQ;
         st_r.readData <= RST_STATUS;
         st_r.ack <= 1'b0;
         st_r.powerOn <= 1'b0;
         st_r.groupSmi <= 1'b0;
         st_r.smiPinOut <= 1'b1;
         st_r.smiPinOe_n <= 1'b1;
         st_r.irq <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign powerOnRequest = st_r.powerOn;
   assign groupSmi = st_r.groupSmi;
   assign systemMgmtIrq_n = st_r.smiPinOut;
   assign systemMgmtIrqOe_n = st_r.smiPinOe_n;
   assign irq = st_r.irq;

endmodule : spwss_top

// >>> rtl/spwss_pkg.sv
// Constants and carrier types of the wake status and SMI enable block
package spwss_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus geometry
   localparam int AVS_ADDR_W = 10;
   localparam int AVS_DATA_W = 32;
   localparam int AVS_BE_W = 4;
   localparam int REG_W = 8;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_WAKE_EN_A = 8'hb0;
   localparam logic [7:0] IDX_WAKE_EN_B = 8'hb1;
   localparam logic [7:0] IDX_STATUS_A = 8'hb2;
   localparam logic [7:0] IDX_STATUS_B = 8'hb3;
   localparam logic [7:0] IDX_SMI_EN_A = 8'hb4;
   localparam logic [7:0] IDX_SMI_PIN_CTL = 8'hb5;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hc1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_WAKE_EN_A = 8'h00;
   localparam logic [7:0] RST_WAKE_EN_B = 8'h80;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_SMI_EN = 8'h00;
   localparam logic [7:0] RST_PIN_CTL = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [7:0] RST_PINS = 8'hff;
   localparam logic LATCH_PREV_RST = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Field positions and masks
   localparam int SMI_PIN_EN_BIT = 7;
   localparam logic [7:0] WAKE_EN_B_POWER_MASK = 8'h13;
   localparam logic [7:0] SMI_PIN_CTL_MASK = 8'h80;
   localparam int IRQ_WAKE_A = 0;
   localparam int IRQ_WAKE_B = 1;
   localparam int IRQ_BUTTON = 2;
   localparam int IRQ_SMI = 3;
   localparam logic [7:0] IRQ_IMPL_MASK = 8'h0f;

   // Event latch slots
   localparam int LATCH_N = 10;
   localparam int L_RING_A = 0;
   localparam int L_RING_B = 1;
   localparam int L_KBD_CLK = 2;
   localparam int L_MOUSE_CLK = 3;
   localparam int L_IR_RX_B = 4;
   localparam int L_ALARM = 5;
   localparam int L_SER_RX_A = 6;
   localparam int L_SER_RX_B = 7;
   localparam int L_BUTTON = 8;
   localparam int L_ALARM_B = 9;
   localparam logic [LATCH_N-1:0] LATCH_EDGE_MASK = 10'h1df;
   localparam logic [LATCH_N-1:0] CLR_BY_A_MASK = 10'h03f;
   localparam logic [LATCH_N-1:0] CLR_BY_B_MASK = 10'h3c0;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic buttonPress_n;
      logic serialReceiveB;
      logic serialReceiveA;
      logic infraredReceiveB;
      logic mouseClockWake;
      logic keyboardClockWake;
      logic ringIndPortB;
      logic ringIndPortA;
   } spwss_wake_pins_type;

   typedef struct packed {
      logic watchdogEvent;
      logic groupIrqA;
      logic groupIrqB;
      logic floppyIrq;
      logic serialIrqA;
      logic serialIrqB;
      logic parallelIrq;
      logic driveIfIrq;
   } spwss_periph_irq_type;

   typedef struct packed {
      logic [7:0] wakeEnA;
      logic [7:0] wakeEnB;
      logic [7:0] smiEn;
      logic [7:0] pinCtl;
      logic [7:0] irqStatus;
      logic [7:0] irqMask;
      logic [7:0] readData;
      logic ack;
      logic powerOn;
      logic groupSmi;
      logic smiPinOut;
      logic smiPinOe_n;
      logic irq;
   } spwss_top_state_type;

   typedef struct packed {
      logic prev;
      logic flag;
   } spwss_latch_state_type;

endpackage : spwss_pkg

// >>> rtl/spwss_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module spwss_sync
   import spwss_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } spwss_sync_state_type;

   spwss_sync_state_type st_r;
   spwss_sync_state_type st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // First stage is read only by the second stage
   always_comb begin
      st_nxt.meta = asyncIn;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= {RESET_VAL, RESET_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign syncOut = st_r.stable;

endmodule : spwss_sync

// >>> rtl/spwss_event_latch.sv
// Sticky event latch, set on a falling edge or on a high level
`timescale 1ns/1ps
module spwss_event_latch
   import spwss_pkg::*;
#(
   parameter bit SET_ON_FALL = 1'b1
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic sample,
   input wire logic clear,
   output logic flag,
   output logic setPulse
);

   spwss_latch_state_type st_r;
   spwss_latch_state_type st_nxt;
   logic setNow;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      setNow = SET_ON_FALL ? (st_r.prev & ~sample) : sample;
      st_nxt.prev = sample;
      // Set beats clear so an event during a read is kept
      st_nxt.flag = setNow | (st_r.flag & ~clear);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= {LATCH_PREV_RST, 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;
   assign setPulse = setNow;

endmodule : spwss_event_latch

// >>> tb/spwss_top_props.sv
// Port-level assertions for the wake status and SMI enable block
`timescale 1ns/1ps
module spwss_top_props
   import spwss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [AVS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [AVS_BE_W-1:0] avs_byteenable,
   input wire logic [AVS_DATA_W-1:0] avs_writedata,
   input wire logic [AVS_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire spwss_wake_pins_type wakePins,
   input wire logic rtcAlarm,
   input wire logic clockAlarmSecond,
   input wire spwss_periph_irq_type periphIrq,
   input wire logic powerOnRequest,
   input wire logic groupSmi,
   input wire logic systemMgmtIrq_n,
   input wire logic systemMgmtIrqOe_n,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // Bus answer: exactly one wait state
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   AST_IDLE_NO_WAIT: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest high with no request");
   ////////////////////////////////////////////////////////////////////////
   // SMI gating, one cycle behind the sources
   AST_SMI_NO_SOURCE: assert property ($past(periphIrq) == '0 |-> !groupSmi)
      else $error("group SMI high with no source active");
   AST_SMI_ROSE_CAUSE: assert property ($rose(groupSmi) |-> $past(periphIrq) != '0)
      else $error("group SMI rose without an active source");
   AST_PIN_IDLE_HIGH: assert property (!groupSmi && !$past(groupSmi) |-> systemMgmtIrq_n)
      else $error("SMI pin low while group SMI idle");
   AST_PIN_LOW_CAUSE: assert property (!systemMgmtIrq_n |-> groupSmi || $past(groupSmi))
      else $error("SMI pin low without group SMI");
   ////////////////////////////////////////////////////////////////////////
   // Read data content
   AST_LIVE_GROUP: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == IDX_STATUS_A
      |-> avs_readdata[5:4] == {$past(periphIrq.groupIrqB), $past(periphIrq.groupIrqA)})
      else $error("status A group bits differ from live sources");
   AST_RSVD_B_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == IDX_STATUS_B
      |-> avs_readdata[31:5] == '0 && !avs_readdata[3])
      else $error("status B reserved bits not zero");
endmodule : spwss_top_props
bind spwss_top spwss_top_props u_props (.*);

// >>> tb/spwss_wake_src.sv
// Wake pin model: pins idle at pull-up level, events are low pulses
`timescale 1ns/1ps
module spwss_wake_src
   import spwss_pkg::*;
(
   output spwss_wake_pins_type wakePins
);
   initial wakePins = RST_PINS;
   // Low long enough to pass the pin synchroniser
   task automatic pulse(input int k, ref logic clk);
      wakePins[k] <= 1'b0;
      repeat (4) @(posedge clk);
      wakePins[k] <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : pulse
endmodule : spwss_wake_src

// >>> tb/spwss_top_tb_top.sv
// Self-checking bench: register reads, wake events, SMI gating, interrupt
`timescale 1ns/1ps
module spwss_top_tb_top;
   import spwss_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [AVS_ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [AVS_BE_W-1:0] avs_byteenable = 4'h1;
   logic [AVS_DATA_W-1:0] avs_writedata = '0;
   logic [AVS_DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   spwss_wake_pins_type wakePins;
   logic rtcAlarm = 1'b0;
   logic clockAlarmSecond = 1'b0;
   spwss_periph_irq_type periphIrq = '0;
   logic powerOnRequest, groupSmi, systemMgmtIrq_n, systemMgmtIrqOe_n, irq;
   int errCount = 0;
   int nCompared = 0;
   int cyc = 0;
   logic [31:0] q;
   logic [7:0] latA = '0, latB = '0, en, src;
   int slot [8] = '{0, 1, 2, 3, 6, 8, 9, 10};
   always #50 sys_clk = ~sys_clk;
   spwss_top u_dut (.*);
   spwss_wake_src u_src (.wakePins(wakePins));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errCount++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input bit w, input logic [9:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask : rd
   // Model read of status A: latched bits plus live group bits, then cleared
   task automatic rdA;
      rd(10'h2c8, latA | {2'b00, periphIrq.groupIrqB, periphIrq.groupIrqA, 4'h0});
      latA = '0;
   endtask : rdA
   task automatic rdB;
      rd(10'h2cc, latB);
      latB = '0;
   endtask : rdB
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(8));
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      rd(10'h2c8, 8'h00);
      rd(10'h2cc, 8'h00);
      rd(10'h2d0, 8'h00);
      rd(10'h2c4, 8'h80);
      rd(10'h3fc, 8'h00);
      bus(1'b1, 10'h2cc, 8'hff);
      rd(10'h2cc, 8'h00);
      for (int k = 0; k < 8; k++) begin
         periphIrq <= spwss_periph_irq_type'(8'($urandom));
         u_src.pulse(k, sys_clk);
         if (slot[k] < 8) latA[slot[k]] = 1'b1;
         else latB[slot[k] - 8] = 1'b1;
         repeat (4) @(posedge sys_clk);
         rdA;
         rdB;
         rdA;
      end
      rtcAlarm <= 1'b1;
      clockAlarmSecond <= 1'b1;
      @(posedge sys_clk);
      rtcAlarm <= 1'b0;
      clockAlarmSecond <= 1'b0;
      latA[7] = 1'b1;
      latB[4] = 1'b1;
      repeat (2) @(posedge sys_clk);
      rdA;
      rdB;
      for (int i = 0; i < 24; i++) begin
         en = (i < 8) ? 8'h01 << i : 8'($urandom);
         src = (i < 16) ? 8'h01 << (i % 8) : 8'($urandom);
         bus(1'b1, 10'h2d0, en);
         periphIrq <= src;
         repeat (3) @(posedge sys_clk);
         chk(groupSmi, |(en & src));
         chk(systemMgmtIrq_n, !(|(en & src)));
         chk(systemMgmtIrqOe_n, 1'b1);
      end
      rd(10'h2d0, en);
      bus(1'b1, 10'h2d4, 8'h80);
      repeat (2) @(posedge sys_clk);
      chk(systemMgmtIrqOe_n, 1'b0);
      rd(10'h2d4, 8'h80);
      bus(1'b1, 10'h2d4, 8'h00);
      bus(1'b1, 10'h2d0, 8'h00);
      periphIrq <= '0;
      bus(1'b1, 10'h300, 8'hff);
      bus(1'b1, 10'h304, 8'h01);
      bus(1'b1, 10'h2c0, 8'h01);
      rd(10'h2c0, 8'h01);
      u_src.pulse(0, sys_clk);
      latA[0] = 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(powerOnRequest, 1'b1);
      chk(irq, 1'b1);
      rdA;
      bus(1'b1, 10'h300, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk(powerOnRequest, 1'b0);
      chk(irq, 1'b0);
      bus(1'b1, 10'h304, 8'h00);
      bus(1'b1, 10'h2c4, 8'h04);
      u_src.pulse(7, sys_clk);
      latB[2] = 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(powerOnRequest, 1'b0);
      chk(irq, 1'b0);
      rdB;
      final_report;
   end
endmodule : spwss_top_tb_top
